/* File: hdl/mbd_consts.svh */
// constants for the media bus device channel blocks
`ifndef MBD_CONSTS_SVH
`define MBD_CONSTS_SVH
// ==========================================================
// frame layout
`define MBD_CHANS 8
`define MBD_CH_LOG 5
`define MBD_SYNC_END 7
`define MBD_MISS_MAX 2
`define MBD_GOOD_MIN 3
// ==========================================================
// line codes (undriven lines read as all ones)
`define MBD_SYNC_PAT 8'h5a
`define MBD_IDLE_NO_PAYLOAD_CMD 8'hff
`define MBD_READY 8'hff
`define MBD_BUSY 8'h70
`define MBD_SEQERR 8'h72
// ==========================================================
// timing
`define MBD_CLK_NS 8
`define MBD_LINK_NS 128
`define MBD_HALF_CYC (`MBD_LINK_NS / `MBD_CLK_NS / 2)
`endif

/* File: hdl/mbd_pkg.sv */
// types shared by both ends of the media bus
package mbd_pkg;
  // ========================================================
  // transport methods and packet command kinds
  typedef enum logic [1:0] {
    MBD_M_SYNC = 2'h0, MBD_M_ASYNC = 2'h1, MBD_M_CTRL = 2'h2, MBD_M_ISOC = 2'h3
  } mbd_method_e;
  typedef enum logic [1:0] {
    MBD_K_START = 2'h0, MBD_K_CONT = 2'h1, MBD_K_END = 2'h2, MBD_K_BREAK = 2'h3
  } mbd_kind_e;
  typedef enum logic [1:0] {MBD_UNLK = 2'b01, MBD_LOCK = 2'b10} mbd_lock_e;

  // command code of a method and kind: family nibble, kind in bits 2:1
  function automatic logic [7:0] mbd_cmd(input mbd_method_e m, input mbd_kind_e k);
    mbd_cmd = {2'h0, 2'(m + 2'h1) == 2'h0 ? 2'h0 : 2'(m + 2'h1), 1'b0, k, 1'b0};
    if (m == MBD_M_ISOC)
      mbd_cmd[7:4] = 4'h4;
  endfunction : mbd_cmd

  // true when a code belongs to the method's family
  function automatic logic mbd_of(input mbd_method_e m, input logic [7:0] c);
    logic [7:0] s;
    s = mbd_cmd(m, MBD_K_START);
    mbd_of = (c[7:4] == s[7:4]) && !c[3] && !c[0];
  endfunction : mbd_of

  // ========================================================
  // state of the device end
  typedef struct packed {
    logic c1, c2, c3, s1, s2, d1, d2;
    logic stp, sbit, dbit;
    logic sig_out, sig_oen, data_out, data_oen;
    logic tx_act, first, tx_ready;
    logic [7:0] tx_cmd;
    logic [31:0] tx_sh;
    logic [7:0] rcmd;
    logic [31:0] rdat;
    logic in_pkt, err_pend, rx_valid, seq_err;
    logic [7:0] stat;
    logic [7:0] rx_cmd;
    logic [31:0] rx_data;
  } mbd_dev_s;
endpackage : mbd_pkg

/* File: hdl/mbd_bus_if.sv */
// three-line media bus joining the controller end and a device end
interface mbd_bus_if;
  logic bus_clk;
  logic ctl_sig_out, ctl_sig_oen, ctl_data_out, ctl_data_oen;
  logic dev_sig_out, dev_sig_oen, dev_data_out, dev_data_oen;
  logic sig_line, data_line;

  // ========================================================
  // line resolution: an undriven line floats high
  assign sig_line = !ctl_sig_oen ? ctl_sig_out : (!dev_sig_oen ? dev_sig_out : 1'b1);
  assign data_line = !ctl_data_oen ? ctl_data_out : (!dev_data_oen ? dev_data_out : 1'b1);

  modport ctl (output bus_clk, ctl_sig_out, ctl_sig_oen, ctl_data_out, ctl_data_oen,
    input sig_line, data_line);
  modport dev (input bus_clk, sig_line, data_line,
    output dev_sig_out, dev_sig_oen, dev_data_out, dev_data_oen);
endinterface : mbd_bus_if

/* File: hdl/mbd_frame_lock.sv */
// frame lock tracker: follows the sync pattern and the bit position
`include "mbd_consts.svh"
module mbd_frame_lock #(
  parameter int CHANS = `MBD_CHANS,
  parameter int PW = $clog2(CHANS) + `MBD_CH_LOG
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_bit,
  input wire logic i_sig,
  output logic o_locked,
  output logic [PW-1:0] o_pos
);
  import mbd_pkg::*;

  typedef struct packed {
    mbd_lock_e st;
    logic [7:0] sh;
    logic [PW-1:0] pos;
    logic [1:0] miss;
    logic [1:0] good;
  } mbd_lk_s;

  localparam logic [PW-1:0] EXP = PW'(`MBD_SYNC_END);
  localparam mbd_lk_s RST = '{st: MBD_UNLK, sh: 8'hff, pos: '1, miss: 2'h0, good: 2'h0};

  // position must hold a channel number above the bit count
  generate
    if (CHANS < 2 || PW <= `MBD_CH_LOG)
    begin : g_bad_cfg
      $error("PW too narrow for the channel count");
    end
  endgenerate

  mbd_lk_s r, n;
  logic [7:0] sh;
  logic hit, at_exp;

  // ========================================================
  // per bit: advance position, judge sync at expected place
  always_comb
  begin
    n = r;
    sh = {r.sh[6:0], i_sig};
    hit = (sh == `MBD_SYNC_PAT);
    at_exp = (PW'(r.pos + 1'b1) == EXP);
    if (i_bit)
    begin
      n.sh = sh;
      n.pos = PW'(r.pos + 1'b1);
      unique case (r.st)
        MBD_LOCK:
        begin
          if (at_exp)
          begin
            if (hit)
              n.miss = 2'h0;
            else if (r.miss == 2'(`MBD_MISS_MAX - 1))
            begin
              n.st = MBD_UNLK;
              n.miss = 2'h0;
              n.good = 2'h0;
            end
            else
              n.miss = 2'(r.miss + 2'h1);
          end
          // hits elsewhere are ignored
        end
        MBD_UNLK:
        begin
          if (hit && at_exp)
          begin
            n.good = 2'(r.good + 2'h1);
            if (r.good == 2'(`MBD_GOOD_MIN - 1))
            begin
              n.st = MBD_LOCK;
              n.good = 2'h0;
            end
          end
          else if (hit)
          begin
            n.pos = EXP; // realign to this candidate
            n.good = 2'h1;
          end
          else if (at_exp)
            n.good = 2'h0;
        end
      endcase
    end
  end

  // ========================================================
  // state register
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      r <= RST;
    else
      r <= n;
  end

  assign o_locked = (r.st == MBD_LOCK);
  assign o_pos = r.pos;
endmodule : mbd_frame_lock

/* File: hdl/mbd_device_end.sv */
// device end of the media bus: lock, transmit packets, answer status
`include "mbd_consts.svh"
module mbd_device_end #(
  parameter int CHANS = `MBD_CHANS
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  mbd_bus_if.dev bus,
  input wire logic [$clog2(CHANS)-1:0] i_tx_chan,
  input wire mbd_pkg::mbd_method_e i_tx_method,
  input wire logic i_tx_valid,
  input wire logic [31:0] i_tx_data,
  input wire logic i_tx_last,
  input wire logic i_tx_abort,
  output logic o_tx_ready,
  input wire logic [$clog2(CHANS)-1:0] i_rx_chan,
  input wire mbd_pkg::mbd_method_e i_rx_method,
  input wire logic i_rx_bcast,
  input wire logic i_rx_busy,
  output logic o_rx_valid,
  output logic [7:0] o_rx_cmd,
  output logic [31:0] o_rx_data,
  output logic o_seq_err,
  output logic o_locked
);
  import mbd_pkg::*;

  localparam int CW = $clog2(CHANS);
  localparam int PW = CW + `MBD_CH_LOG;

  // ========================================================
  // parameter check
  generate
    if (CHANS < 2 || (1 << CW) != CHANS)
    begin : g_bad_chans
      $error("CHANS must be a power of two, at least 2");
    end
  endgenerate

  localparam mbd_dev_s RST = '{sig_oen: 1'b1, data_oen: 1'b1, first: 1'b1,
    sig_out: 1'b1, data_out: 1'b1, c1: 1'b0, c2: 1'b0, c3: 1'b0, s1: 1'b1,
    s2: 1'b1, d1: 1'b1, d2: 1'b1, sbit: 1'b1, dbit: 1'b1, stat: `MBD_READY,
    tx_cmd: `MBD_IDLE_NO_PAYLOAD_CMD, rcmd: `MBD_IDLE_NO_PAYLOAD_CMD, rx_cmd: `MBD_IDLE_NO_PAYLOAD_CMD, default: '0};

  mbd_dev_s r, n;
  logic locked;
  logic [PW-1:0] pos, npos;
  logic [CW-1:0] ch, nch;
  logic [4:0] b, nb;
  logic [7:0] c;
  logic err, stat_on;

  // ========================================================
  // frame lock counts each bit one cycle before the step, so pos is current there
  mbd_frame_lock #(.CHANS(CHANS), .PW(PW)) u_lock (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_bit(r.c2 && !r.c3),
    .i_sig(r.s2),
    .o_locked(locked),
    .o_pos(pos)
  );

  // position of the bit just sampled and of the bit to drive next
  assign npos = PW'(pos + 1'b1);
  assign ch = pos[PW-1:5];
  assign b = pos[4:0];
  assign nch = npos[PW-1:5];
  assign nb = npos[4:0];
  assign c = {r.rcmd[6:0], r.sbit};
  // receive status only for async and control, broadcast or not, and for non-broadcast isoc
  assign stat_on = (i_rx_method != MBD_M_SYNC)
    && !(i_rx_method == MBD_M_ISOC && i_rx_bcast);

  // ========================================================
  // next state: pins synchronised, then one step per bus bit
  always_comb
  begin
    n = r;
    err = 1'b0;
    n.c1 = bus.bus_clk;
    n.c2 = r.c1;
    n.c3 = r.c2;
    n.s1 = bus.sig_line;
    n.s2 = r.s1;
    n.d1 = bus.data_line;
    n.d2 = r.d1;
    n.stp = r.c2 && !r.c3; // rising edge of the bus clock
    n.sbit = r.s2;
    n.dbit = r.d2;
    n.tx_ready = 1'b0;
    n.rx_valid = 1'b0;
    n.seq_err = 1'b0;
    // step one cycle after the edge so the lock position is current
    if (r.stp)
    begin
      // receive side: command byte then the data quadlet
      if (ch == i_rx_chan)
      begin
        if (b < 5'd8)
          n.rcmd = c;
        n.rdat = {r.rdat[30:0], r.dbit};
        if (b == 5'd7)
        begin
          if ((i_rx_method == MBD_M_CTRL || i_rx_method == MBD_M_ASYNC)
            && mbd_of(i_rx_method, c))
          begin
            // packet sequence
            unique case (mbd_kind_e'(c[2:1]))
              MBD_K_START:
              begin
                err = r.in_pkt;
                n.in_pkt = 1'b1;
              end
              MBD_K_CONT: err = !r.in_pkt;
              MBD_K_END:
              begin
                err = !r.in_pkt;
                n.in_pkt = 1'b0;
              end
              MBD_K_BREAK: n.in_pkt = 1'b0;
            endcase
          end
          // status of this quadlet reports an error seen earlier
          n.stat = r.err_pend ? `MBD_SEQERR : (i_rx_busy ? `MBD_BUSY : `MBD_READY);
          n.err_pend = err;
          n.seq_err = err;
        end
        if (b == 5'd31 && r.rcmd != `MBD_IDLE_NO_PAYLOAD_CMD
          && !(mbd_of(i_rx_method, r.rcmd) && r.rcmd[2:1] == 2'(MBD_K_BREAK)))
        begin
          n.rx_valid = 1'b1;
          n.rx_cmd = r.rcmd;
          n.rx_data = {r.rdat[30:0], r.dbit};
        end
      end
      // transmit side: choose the channel's command at its first bit
      if (nb == 5'd0)
      begin
        n.tx_act = 1'b0;
        if (nch == i_tx_chan && locked)
        begin
          if (i_tx_method == MBD_M_SYNC || i_tx_method == MBD_M_ISOC)
          begin
            if (i_tx_valid)
            begin
              n.tx_act = 1'b1;
              n.tx_cmd = mbd_cmd(i_tx_method, MBD_K_START);
              n.tx_sh = i_tx_data;
              n.tx_ready = 1'b1;
            end
          end
          else if (i_tx_abort && !r.first)
          begin
            n.tx_act = 1'b1;
            n.tx_cmd = mbd_cmd(i_tx_method, MBD_K_BREAK);
            n.tx_sh = '1;
            n.tx_ready = 1'b1; // the abort request was served
            n.first = 1'b1;
          end
          else if (i_tx_valid)
          begin
            n.tx_act = 1'b1;
            n.tx_cmd = mbd_cmd(i_tx_method, r.first ? MBD_K_START
              : (i_tx_last ? MBD_K_END : MBD_K_CONT));
            n.tx_sh = i_tx_data;
            n.tx_ready = 1'b1;
            n.first = i_tx_last;
          end
        end
      end
      // drive the next bit; an idle signal line reads no-payload
      n.sig_oen = 1'b1;
      n.data_oen = 1'b1;
      n.sig_out = 1'b1;
      n.data_out = 1'b1;
      if (locked && n.tx_act)
      begin
        n.data_oen = 1'b0;
        n.data_out = n.tx_sh[5'd31 - nb];
        if (nb < 5'd8)
        begin
          n.sig_oen = 1'b0;
          n.sig_out = n.tx_cmd[3'(5'd7 - nb)];
        end
      end
      if (locked && stat_on && nch == i_rx_chan && nb >= 5'd8 && nb < 5'd16)
      begin
        n.sig_oen = 1'b0;
        n.sig_out = n.stat[3'(5'd15 - nb)];
      end
    end
    // losing lock releases both lines at once
    if (!locked)
    begin
      n.sig_oen = 1'b1;
      n.data_oen = 1'b1;
      n.tx_act = 1'b0;
      n.in_pkt = 1'b0;
    end
  end

  // ========================================================
  // state register
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      r <= RST;
    else
      r <= n;
  end

  // ========================================================
  // outputs, all from flip-flops
  assign bus.dev_sig_out = r.sig_out;
  assign bus.dev_sig_oen = r.sig_oen;
  assign bus.dev_data_out = r.data_out;
  assign bus.dev_data_oen = r.data_oen;
  assign o_tx_ready = r.tx_ready;
  assign o_rx_valid = r.rx_valid;
  assign o_rx_cmd = r.rx_cmd;
  assign o_rx_data = r.rx_data;
  assign o_seq_err = r.seq_err;
  assign o_locked = locked; // flop inside the tracker
endmodule : mbd_device_end

/* File: hdl/mbd_ctrl_end.sv */
// controller end of the media bus: makes the clock and frame, moves quadlets
`include "mbd_consts.svh"
module mbd_ctrl_end #(
  parameter int CHANS = `MBD_CHANS
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  mbd_bus_if.ctl bus,
  input wire logic [$clog2(CHANS)-1:0] i_tx_chan,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_cmd,
  input wire logic [31:0] i_tx_data,
  output logic o_tx_ready,
  input wire logic [$clog2(CHANS)-1:0] i_rx_chan,
  output logic o_rx_valid,
  output logic [7:0] o_rx_cmd,
  output logic [31:0] o_rx_data,
  output logic o_stat_valid,
  output logic [7:0] o_stat
);
  import mbd_pkg::*;

  localparam int CW = $clog2(CHANS);
  localparam int PW = CW + `MBD_CH_LOG;
  localparam logic [7:0] HALF = 8'(`MBD_HALF_CYC);
  localparam logic [7:0] SYNC = `MBD_SYNC_PAT;

  generate
    if (CHANS < 2 || (1 << CW) != CHANS || `MBD_HALF_CYC < 4)
    begin : g_bad_cfg
      $error("CHANS must be a power of two and the bus clock slow enough");
    end
  endgenerate

  typedef struct packed {
    logic [7:0] div;
    logic clk;
    logic [PW-1:0] pos;
    logic s1, s2, d1, d2;
    logic sig_out, sig_oen, data_out, data_oen;
    logic act, tx_ready;
    logic [7:0] cmd;
    logic [31:0] sh;
    logic [7:0] rcmd;
    logic [31:0] rdat;
    logic [7:0] rst_sh;
    logic rx_valid, stat_valid;
    logic [7:0] stat;
  } mbd_ctl_s;

  localparam mbd_ctl_s RST = '{pos: '1, sig_oen: 1'b1, data_oen: 1'b1, sig_out: 1'b1,
    data_out: 1'b1, s1: 1'b1, s2: 1'b1, d1: 1'b1, d2: 1'b1, default: '0};

  mbd_ctl_s r, n;
  logic [PW-1:0] np;
  logic [CW-1:0] ch, nch;
  logic [4:0] b, nb;

  assign np = PW'(r.pos + 1'b1);
  assign ch = r.pos[PW-1:5];
  assign b = r.pos[4:0];
  assign nch = np[PW-1:5];
  assign nb = np[4:0];

  // ========================================================
  // divider toggles the bus clock; drive on fall, sample on rise
  always_comb
  begin
    n = r;
    n.s1 = bus.sig_line;
    n.s2 = r.s1;
    n.d1 = bus.data_line;
    n.d2 = r.d1;
    n.tx_ready = 1'b0;
    n.rx_valid = 1'b0;
    n.stat_valid = 1'b0;
    n.div = 8'(r.div + 8'h1);
    if (r.div == HALF - 8'h1)
    begin
      n.div = 8'h0;
      n.clk = !r.clk;
      if (r.clk)
      begin
        // falling edge: present the next bit
        n.pos = np;
        if (nb == 5'd0)
        begin
          n.act = 1'b0;
          if (nch == i_tx_chan && i_tx_valid)
          begin
            n.act = 1'b1;
            n.cmd = i_tx_cmd;
            n.sh = i_tx_data;
            n.tx_ready = 1'b1;
          end
        end
        n.sig_oen = 1'b1;
        n.sig_out = 1'b1;
        n.data_oen = !n.act;
        n.data_out = n.sh[5'd31 - nb];
        if (nb < 5'd8 && nch == '0)
        begin
          n.sig_oen = 1'b0;
          n.sig_out = SYNC[3'(5'd7 - nb)];
        end
        else if (nb < 5'd8 && n.act)
        begin
          n.sig_oen = 1'b0;
          n.sig_out = n.cmd[3'(5'd7 - nb)];
        end
      end
      else
      begin
        // rising edge: take the bit at the current position
        if (ch == i_rx_chan)
        begin
          if (b < 5'd8)
            n.rcmd = {r.rcmd[6:0], r.s2};
          n.rdat = {r.rdat[30:0], r.d2};
          if (b == 5'd31 && r.rcmd != `MBD_IDLE_NO_PAYLOAD_CMD)
          begin
            n.rx_valid = 1'b1;
            n.rdat = {r.rdat[30:0], r.d2};
          end
        end
        if (ch == i_tx_chan && b >= 5'd8 && b < 5'd16)
        begin
          n.rst_sh = {r.rst_sh[6:0], r.s2};
          if (b == 5'd15 && r.act)
          begin
            n.stat_valid = 1'b1;
            n.stat = {r.rst_sh[6:0], r.s2};
          end
        end
      end
    end
  end

  // ========================================================
  // state register
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      r <= RST;
    else
      r <= n;
  end

  assign bus.bus_clk = r.clk;
  assign bus.ctl_sig_out = r.sig_out;
  assign bus.ctl_sig_oen = r.sig_oen;
  assign bus.ctl_data_out = r.data_out;
  assign bus.ctl_data_oen = r.data_oen;
  assign o_tx_ready = r.tx_ready;
  assign o_rx_valid = r.rx_valid;
  assign o_rx_cmd = r.rcmd;
  assign o_rx_data = r.rdat;
  assign o_stat_valid = r.stat_valid;
  assign o_stat = r.stat;
endmodule : mbd_ctrl_end

/* File: verif/mbd_bus_chk.sv */
// concurrent checks on the media bus wires between the controller and device ends
module mbd_bus_chk (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic bus_clk,
  input wire logic dev_sig_out,
  input wire logic dev_sig_oen,
  input wire logic dev_data_out,
  input wire logic dev_data_oen,
  input wire logic ctl_sig_oen,
  input wire logic sig_line
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // drive length counters
  logic [7:0] sig_len_r;
  logic [9:0] dat_len_r;

  // cycles each device pin has been driven, cleared on release
  always_ff @(posedge i_clock)
  begin
    sig_len_r <= (i_sys_rst || dev_sig_oen) ? 8'h00 : sig_len_r + 8'h01;
    dat_len_r <= (i_sys_rst || dev_data_oen) ? 10'h000 : dat_len_r + 10'h001;
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  a_bclk_high_len: assert property ($rose(bus_clk) |-> bus_clk [*8] ##1 !bus_clk)
    else $error("bus clock high phase is not eight cycles");
  a_bclk_low_len: assert property ($fell(bus_clk) |-> !bus_clk [*8] ##1 bus_clk)
    else $error("bus clock low phase is not eight cycles");
  a_idle_no_payload: assert property (ctl_sig_oen && dev_sig_oen |-> sig_line)
    else $error("undriven signal line does not read high");
  a_sig_byte_len: assert property ($rose(dev_sig_oen) |-> sig_len_r == 8'h80)
    else $error("device signal drive is not one byte long");
  a_data_quad_len: assert property ($rose(dev_data_oen) |-> dat_len_r == 10'h200)
    else $error("device data drive is not one quadlet long");
  a_cmd_with_data: assert property ($fell(dev_data_oen) |-> $fell(dev_sig_oen))
    else $error("quadlet started without its command");
  a_status_alone: assert property ($fell(dev_sig_oen) && dev_data_oen |=> dev_data_oen [*8])
    else $error("status byte came with data drive");
  a_data_bit_hold: assert property ($changed(dev_data_out) && !dev_data_oen |=>
    (dev_data_oen || $stable(dev_data_out)) [*8])
    else $error("device data bit changed too soon");
  a_sig_bit_hold: assert property ($changed(dev_sig_out) && !dev_sig_oen |=>
    (dev_sig_oen || $stable(dev_sig_out)) [*8])
    else $error("device signal bit changed too soon");

  c_cmd_sent: cover property ($fell(dev_data_oen));
  c_status_sent: cover property ($fell(dev_sig_oen) && dev_data_oen);
  c_quad_done: cover property ($rose(dev_data_oen));
endmodule : mbd_bus_chk

/* File: verif/tb_media_bus_device_channel_protocol.sv */
// testbench: controller end and device end on one bus, a spare device on a driven bus
module tb_media_bus_device_channel_protocol;
  timeunit 1ns;
  timeprecision 100ps;
  import mbd_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [2:0] d_tx_chan = 3'h2, d_rx_chan = 3'h3, c_tx_chan = 3'h3, c_rx_chan = 3'h2;
  mbd_method_e d_tx_method = MBD_M_CTRL, d_rx_method = MBD_M_CTRL;
  logic d_tx_valid = 1'b0, d_tx_last = 1'b0, d_tx_abort = 1'b0;
  logic d_rx_bcast = 1'b0, d_rx_busy = 1'b0, c_tx_valid = 1'b0;
  logic [31:0] d_tx_data = 32'h0, c_tx_data = 32'h0;
  logic [7:0] c_tx_cmd = 8'hff;
  logic d_tx_ready, d_rx_valid, d_seq_err, d_locked, d_locked_b;
  logic c_tx_ready, c_rx_valid, c_stat_valid;
  logic [7:0] d_rx_cmd, c_rx_cmd, c_stat;
  logic [31:0] d_rx_data, c_rx_data;
  int fails = 0, checked = 0, seq_cnt = 0, cycles = 0;

  mbd_bus_if bus_a ();
  mbd_bus_if bus_b ();

  mbd_ctrl_end mbd_ctrl_end_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .bus(bus_a.ctl),
    .i_tx_chan(c_tx_chan), .i_tx_valid(c_tx_valid), .i_tx_cmd(c_tx_cmd), .i_tx_data(c_tx_data),
    .o_tx_ready(c_tx_ready), .i_rx_chan(c_rx_chan), .o_rx_valid(c_rx_valid),
    .o_rx_cmd(c_rx_cmd), .o_rx_data(c_rx_data), .o_stat_valid(c_stat_valid), .o_stat(c_stat));
  mbd_device_end mbd_device_end_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .bus(bus_a.dev),
    .i_tx_chan(d_tx_chan), .i_tx_method(d_tx_method), .i_tx_valid(d_tx_valid),
    .i_tx_data(d_tx_data), .i_tx_last(d_tx_last), .i_tx_abort(d_tx_abort),
    .o_tx_ready(d_tx_ready), .i_rx_chan(d_rx_chan), .i_rx_method(d_rx_method),
    .i_rx_bcast(d_rx_bcast), .i_rx_busy(d_rx_busy), .o_rx_valid(d_rx_valid),
    .o_rx_cmd(d_rx_cmd), .o_rx_data(d_rx_data), .o_seq_err(d_seq_err), .o_locked(d_locked));
  // spare device: the bench plays the controller and breaks the sync pattern
  mbd_device_end mbd_device_end_b_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .bus(bus_b.dev), .i_tx_chan(d_tx_chan), .i_tx_method(d_tx_method), .i_tx_valid(d_tx_valid),
    .i_tx_data(d_tx_data), .i_tx_last(d_tx_last), .i_tx_abort(d_tx_abort), .o_tx_ready(),
    .i_rx_chan(d_rx_chan), .i_rx_method(d_rx_method), .i_rx_bcast(d_rx_bcast),
    .i_rx_busy(d_rx_busy), .o_rx_valid(), .o_rx_cmd(), .o_rx_data(), .o_seq_err(),
    .o_locked(d_locked_b));
  mbd_bus_chk mbd_bus_chk_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .bus_clk(bus_a.bus_clk), .dev_sig_out(bus_a.dev_sig_out), .dev_sig_oen(bus_a.dev_sig_oen),
    .dev_data_out(bus_a.dev_data_out), .dev_data_oen(bus_a.dev_data_oen),
    .ctl_sig_oen(bus_a.ctl_sig_oen), .sig_line(bus_a.sig_line));

  // ==========================================================
  // clock, cycle limit and error pulse count
  initial
  begin
    forever #4 i_clock = ~i_clock;
  end

  always @(posedge i_clock)
  begin
    cycles++;
    if (d_seq_err === 1'b1)
      seq_cnt++;
    if (cycles == 90000)
    begin
      fails++;
      stop_test();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // wait at clock edges for a signal to be seen high, bounded
  task automatic wait_hi(ref logic s, input int lim, input string name);
    int n;
    n = 0;
    do
    begin
      @(posedge i_clock);
      n++;
    end
    while (s !== 1'b1 && n < lim);
    check(name, s, 1'b1);
  endtask : wait_hi

  // one quadlet from the device end, read back by the controller
  task automatic dev_word(input mbd_method_e m, input logic [31:0] dat, input logic last,
    input logic abort, input logic [7:0] exp);
    @(posedge i_clock);
    #1;
    d_tx_method = m;
    d_tx_data = dat;
    d_tx_last = last;
    d_tx_abort = abort;
    d_tx_valid = 1'b1;
    wait_hi(d_tx_ready, 6000, "dev_tx_ready");
    #1;
    d_tx_valid = 1'b0;
    d_tx_abort = 1'b0;
    wait_hi(c_rx_valid, 700, "ctl_rx_valid");
    check("ctl_rx_cmd", c_rx_cmd, exp);
    check("ctl_rx_data", c_rx_data, abort ? 32'hffffffff : dat);
  endtask : dev_word

  // one command from the controller; judge the status byte and the device's drive of it
  task automatic ctl_word(input logic [7:0] cmd, input mbd_method_e m, input logic bc,
    input logic busy, input logic [7:0] stat, input logic drv);
    int n;
    int low;
    @(posedge i_clock);
    #1;
    d_rx_method = m;
    d_rx_bcast = bc;
    d_rx_busy = busy;
    c_tx_cmd = cmd;
    c_tx_data = {cmd, cmd, 16'ha5c3};
    c_tx_valid = 1'b1;
    wait_hi(c_tx_ready, 6000, "ctl_tx_ready");
    #1;
    c_tx_valid = 1'b0;
    n = 0;
    low = 0;
    do
    begin
      @(posedge i_clock);
      n++;
      low += int'(bus_a.dev_sig_oen === 1'b0);
    end
    while (c_stat_valid !== 1'b1 && n < 700);
    check("status", c_stat, stat);
    check("status_driven", low != 0, drv);
    wait_hi(d_rx_valid, 700, "dev_rx_valid");
    check("dev_rx_cmd", d_rx_cmd, cmd);
    check("dev_rx_data", d_rx_data, {cmd, cmd, 16'ha5c3});
  endtask : ctl_word

  // one frame on the spare bus: sync at position 0 if asked, a second copy at extra
  task automatic frame_b(input logic at0, input int extra, output int drv);
    int p;
    int k;
    logic [7:0] pat;
    pat = 8'h5a;
    drv = 0;
    for (p = 0; p < 256; p++)
    begin
      k = (p < 8) ? p : p - extra;
      bus_b.bus_clk = 1'b0;
      bus_b.ctl_sig_oen = !((at0 && p < 8) || (p >= extra && p < extra + 8));
      bus_b.ctl_sig_out = bus_b.ctl_sig_oen ? 1'b1 : pat[7 - k];
      #62.5;
      bus_b.bus_clk = 1'b1;
      drv += int'(bus_b.dev_sig_oen === 1'b0 || bus_b.dev_data_oen === 1'b0);
      #62.5;
    end
  endtask : frame_b

  // ==========================================================
  // scenarios
  task automatic spare_bus();
    int d;
    repeat (2) frame_b(1'b1, -100, d);
    check("lock_after_two", d_locked_b, 1'b0);
    frame_b(1'b1, -100, d);
    check("lock_after_three", d_locked_b, 1'b1);
    repeat (2) frame_b(1'b1, 40, d);
    repeat (2) frame_b(1'b1, -100, d);
    check("lock_keeps_slot", d_locked_b, 1'b1);
    frame_b(1'b0, -100, d);
    check("lock_one_miss", d_locked_b, 1'b1);
    frame_b(1'b0, -100, d);
    check("unlock_two_miss", d_locked_b, 1'b0);
    frame_b(1'b0, 40, d);
    check("quiet_unlocked", d, 0);
  endtask : spare_bus

  task automatic main_bus();
    wait_hi(d_locked, 20000, "dev_locked");
    fork
      begin
        dev_word(MBD_M_ASYNC, 32'h11223344, 1'b0, 1'b0, 8'h20);
        dev_word(MBD_M_ASYNC, 32'h55667788, 1'b1, 1'b0, 8'h24);
        dev_word(MBD_M_CTRL, 32'h0badcafe, 1'b0, 1'b0, 8'h30);
        dev_word(MBD_M_CTRL, 32'h00000000, 1'b0, 1'b1, 8'h36);
        dev_word(MBD_M_CTRL, 32'h0badcafe, 1'b0, 1'b0, 8'h30);
        dev_word(MBD_M_CTRL, 32'h80000001, 1'b0, 1'b0, 8'h32);
        dev_word(MBD_M_CTRL, 32'h7ffffffe, 1'b1, 1'b0, 8'h34);
        dev_word(MBD_M_SYNC, 32'hc3c3a5a5, 1'b1, 1'b0, 8'h10);
        dev_word(MBD_M_ISOC, 32'h3c3c5a5a, 1'b1, 1'b0, 8'h40);
      end
      begin
        ctl_word(8'h30, MBD_M_CTRL, 1'b0, 1'b0, 8'hff, 1'b1);
        ctl_word(8'h32, MBD_M_CTRL, 1'b0, 1'b1, 8'h70, 1'b1);
        ctl_word(8'h30, MBD_M_CTRL, 1'b0, 1'b0, 8'hff, 1'b1);
        ctl_word(8'h34, MBD_M_CTRL, 1'b0, 1'b0, 8'h72, 1'b1);
        check("seq_errors", seq_cnt, 1);
        ctl_word(8'h10, MBD_M_SYNC, 1'b0, 1'b0, 8'hff, 1'b0);
        ctl_word(8'h40, MBD_M_ISOC, 1'b0, 1'b1, 8'h70, 1'b1);
        ctl_word(8'h40, MBD_M_ISOC, 1'b1, 1'b0, 8'hff, 1'b0);
      end
    join
  endtask : main_bus

  // reset, then both buses run side by side
  initial
  begin
    bus_b.bus_clk = 1'b0;
    bus_b.ctl_sig_out = 1'b1;
    bus_b.ctl_sig_oen = 1'b1;
    bus_b.ctl_data_out = 1'b1;
    bus_b.ctl_data_oen = 1'b1;
    repeat (20) @(posedge i_clock);
    #1;
    i_sys_rst = 1'b0;
    fork
      spare_bus();
      main_bus();
    join
    stop_test();
  end
endmodule : tb_media_bus_device_channel_protocol
